// ---- verilog/hsc_seq.sv ----
// Sealing-cycle sequencer: start delay, sealing, cooling, relay/output modes, alarm.
// Assumes an AHB-Lite master, pins on start/reset/standby heat, temperature and
// error code from logic on the same clock.
// Notes on behaviour
// - With time control on, start launches delay, sealing, cooling and relay action.
// - Reset aborts; in monitoring mode releasing start before cooling ends aborts.
// - Cooling ends below a temperature, at a percentage of target, or after time.
// - Heating-start option: sealing countdown begins when starting delay expires.
// - Zero delay with heating-start: sealing countdown begins at start itself.
// - Temperature-reached option: sealing countdown waits for 95 percent of target.
// - Relay modes apply only while time control is enabled.
// - Off mode keeps the process relay open throughout.
// - Start-present mode: closed from start until cooling completes.
// - Temperature-reached mode: closed from 95 percent until cooling completes.
// - While-cooling mode: closed from end of sealing to end of cooling.
// - End-of-cycle mode: closes at cooling end, reopens after about 500 ms.
// - End-of-cycle pulse opens at once when start is asserted.
// - In-tolerance mode: closed exactly while temperature is inside the band.
// - Latched mode: one excursion during sealing opens it until next start.
// - Auxiliary output offers the same seven modes, latched mode by default.
// - Standby heat suppressed during sealing and the wait for 95 percent, kept in delay and cooling.
// - Calibration errors open the alarm contact, closed while start is active.
// - Hard-fault error codes close the alarm contact.
// - Inverted alarm polarity inverts every alarm contact state.
`timescale 1ns/1ns
`default_nettype none
module hsc_seq import hsc_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC  // Clock cycles per 0.1 s tick
) (
  input wire logic clk,                   // 100 MHz clock
  input wire logic sys_rst,               // Synchronous reset, active high
  input wire logic hsel,                  // AHB select
  input wire logic [31:0] haddr,          // AHB address
  input wire logic [1:0] htrans,          // AHB transfer type
  input wire logic hwrite,                // AHB write
  input wire logic [2:0] hsize,           // AHB size, word only
  input wire logic [31:0] hwdata,         // AHB write data
  input wire logic hready,                // AHB bus ready
  output logic hreadyout,                 // AHB slave ready
  output logic hresp,                     // AHB response, always OKAY
  output logic [31:0] hrdata,             // AHB read data
  input wire logic start_in,              // Start pin
  input wire logic reset_in,              // Reset pin
  input wire logic standby_heat_input,    // Standby heat request pin
  input wire logic [9:0] temp_act,        // Measured temperature
  input wire logic [9:0] err_code,        // Active error code, 0 when none
  output logic process_relay,             // Process relay drive
  output logic aux_output,                // Auxiliary switching output
  output logic seal_heat,                 // Sealing heat on
  output logic standby_heat,              // Standby heat on
  output logic alarm_relay                // Alarm contact closed
);
  logic [2:0] sync1_r, sync2_r;
  logic start_d_r;
  logic [23:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  hsc_ctrl_t ctrl_r, ctrl_nxt;
  hsc_time_t time_r, time_nxt;
  hsc_pair_t temp_r, temp_nxt, band_r, band_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wad_r, wad_nxt;
  logic [31:0] hrdata_nxt;
  hsc_state_t st_r, st_nxt;
  logic [9:0] cnt_r, cnt_nxt;
  logic reached_r, reached_nxt, latch_r, latch_nxt, eoc_r, eoc_nxt;
  logic [3:0] ecnt_r, ecnt_nxt;
  logic [1:0] out_r, out_nxt;
  logic seal_heat_nxt, standby_nxt, alarm_nxt;
  logic start_s, reset_s, heat_s, start_rise;
  logic tc_en, acc, busy, reach95, in_band, cool_done, dly_done, abort, err_cal, err_hard;
  logic [19:0] t100, tgt95, tgt_cv;

  assign start_s = sync2_r[0];
  assign reset_s = sync2_r[1];
  assign heat_s = sync2_r[2];
  assign start_rise = start_s & ~start_d_r;
  assign tc_en = ctrl_r.tc_mode != TC_OFF;
  assign busy = st_r != ST_IDLE;
  assign t100 = 20'(temp_act) * PCT_FULL;
  assign tgt95 = 20'(temp_r.lo) * PCT_REACH;
  assign tgt_cv = 20'(temp_r.lo) * 20'(temp_r.hi);
  assign reach95 = t100 >= tgt95;
  assign in_band = ({1'b0, temp_act} + {1'b0, band_r.lo} >= {1'b0, temp_r.lo})
                && ({1'b0, temp_act} <= {1'b0, temp_r.lo} + {1'b0, band_r.hi});
  assign err_cal = (err_code >= ERR_CAL_LO && err_code <= ERR_CAL_HI)
                || (err_code >= ERR_CAL2_LO && err_code <= ERR_CAL2_HI) || err_code == ERR_CFG;
  assign err_hard = (err_code >= ERR_EXT_LO && err_code <= ERR_EXT_HI)
                 || (err_code >= ERR_STEP_LO && err_code <= ERR_STEP_HI)
                 || (err_code >= ERR_FRQ_LO && err_code <= ERR_FRQ_HI) || err_code == ERR_JMP
                 || (err_code >= ERR_INT_LO && err_code <= ERR_INT_HI);
  assign acc = hsel & htrans[1] & hready;

  // Bus slave; reads see a write finishing in the same cycle
  always_comb begin
    ctrl_nxt = ctrl_r;
    time_nxt = time_r;
    temp_nxt = temp_r;
    band_nxt = band_r;
    wr_pend_nxt = acc & hwrite;
    wad_nxt = haddr[7:0];
    tick_nxt = tick_cnt_r == 24'(TICK_CYCLES - 1);
    tick_cnt_nxt = tick_nxt ? 24'h000000 : tick_cnt_r + 24'h000001;
    if (wr_pend_r) begin
      unique case (wad_r)
        OFS_CTRL: ctrl_nxt = hwdata;
        OFS_TIME: time_nxt = hwdata;
        OFS_TEMP: temp_nxt = hwdata;
        OFS_BAND: band_nxt = hwdata;
        default: ;
      endcase
    end
    ctrl_nxt.rsvd = '0;
    time_nxt.rsvd1 = '0;
    time_nxt.rsvd0 = '0;
    temp_nxt.rsvd1 = '0;
    temp_nxt.rsvd0 = '0;
    band_nxt.rsvd1 = '0;
    band_nxt.rsvd0 = '0;
    hrdata_nxt = 32'h00000000;
    if (acc && !hwrite) begin
      unique case (haddr[7:0])
        OFS_CTRL: hrdata_nxt = ctrl_nxt;
        OFS_TIME: hrdata_nxt = time_nxt;
        OFS_TEMP: hrdata_nxt = temp_nxt;
        OFS_BAND: hrdata_nxt = band_nxt;
        OFS_STAT: hrdata_nxt = {12'h000, cnt_r, eoc_r, latch_r, reached_r, out_r, st_r};
        default: ;
      endcase
    end
  end

  // Cycle sequencer
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    reached_nxt = reached_r;
    latch_nxt = latch_r;
    eoc_nxt = eoc_r;
    ecnt_nxt = ecnt_r;
    unique case (ctrl_r.cool_mode)
      CM_REL: cool_done = t100 <= tgt_cv;
      CM_TIME: cool_done = cnt_r == 10'h000;
      default: cool_done = temp_act < temp_r.hi;
    endcase
    dly_done = (st_r == ST_IDLE) ? (tc_en && start_rise && time_r.delay == 7'h00)
                                 : (st_r == ST_DLY && cnt_r == 10'h000);
    abort = reset_s || !tc_en || (ctrl_r.tc_mode == TC_MON && !start_s);
    if (start_rise) begin
      latch_nxt = 1'b0;
      reached_nxt = 1'b0;
    end
    if (st_r == ST_SEAL && !in_band) latch_nxt = 1'b1;
    if (busy && reach95) reached_nxt = 1'b1;
    if (tick_r && ecnt_r != 4'h0) ecnt_nxt = ecnt_r - 4'h1;
    if (eoc_r && (ecnt_r == 4'h0 || start_rise)) eoc_nxt = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (tc_en && start_rise) begin
          st_nxt = ST_DLY;
          cnt_nxt = 10'(time_r.delay);
        end
      end
      ST_DLY: begin
        if (!dly_done && tick_r) cnt_nxt = cnt_r - 10'h001;
      end
      ST_WAIT: begin
        if (reach95) begin
          st_nxt = ST_SEAL;
          cnt_nxt = time_r.seal_t;
        end
      end
      ST_SEAL: begin
        if (ctrl_r.input_length_sealing ? !start_s : cnt_r == 10'h000) begin
          st_nxt = ST_COOL;
          cnt_nxt = temp_r.hi;
        end else if (tick_r) begin
          cnt_nxt = cnt_r - 10'h001;
        end
      end
      ST_COOL: begin
        if (cool_done) begin
          st_nxt = ST_IDLE;
          eoc_nxt = 1'b1;
          ecnt_nxt = EOC_TICKS;
        end else if (tick_r && cnt_r != 10'h000) begin
          cnt_nxt = cnt_r - 10'h001;
        end
      end
    endcase
    if (dly_done) begin
      st_nxt = ctrl_r.seal_on_heat ? ST_SEAL : ST_WAIT;
      cnt_nxt = time_r.seal_t;
    end
    if (abort && (busy || st_nxt != ST_IDLE)) begin
      st_nxt = ST_IDLE;
      eoc_nxt = eoc_r & ~start_rise;
    end
    seal_heat_nxt = st_nxt == ST_WAIT || st_nxt == ST_SEAL;
    standby_nxt = heat_s && !(tc_en && (st_r == ST_SEAL || st_r == ST_WAIT));
    alarm_nxt = (err_hard || (err_cal && start_s)) ^ ctrl_r.alarm_inv;
  end

  // Process relay and auxiliary output, same mode set
  for (genvar g = 0; g < 2; g++) begin : g_out
    hsc_omode_t m;
    assign m = hsc_omode_t'(g == 0 ? ctrl_r.relay_mode : ctrl_r.aux_mode);
    always_comb begin
      if (!tc_en) begin
        out_nxt[g] = (g == 1) && in_band;
      end else begin
        unique case (m)
          OM_START: out_nxt[g] = busy;
          OM_REACH: out_nxt[g] = busy && reached_r;
          OM_COOL: out_nxt[g] = st_r == ST_COOL;
          OM_EOC: out_nxt[g] = eoc_r && !start_rise;
          OM_TOL: out_nxt[g] = in_band;
          OM_LATCH: out_nxt[g] = in_band && !latch_r;
          default: out_nxt[g] = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      start_d_r <= 1'b0;
      tick_cnt_r <= 24'h000000;
      tick_r <= 1'b0;
      ctrl_r <= RST_CTRL;
      time_r <= RST_TIME;
      temp_r <= RST_TEMP;
      band_r <= RST_BAND;
      wr_pend_r <= 1'b0;
      wad_r <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      st_r <= ST_IDLE;
      cnt_r <= 10'h000;
      reached_r <= 1'b0;
      latch_r <= 1'b0;
      eoc_r <= 1'b0;
      ecnt_r <= 4'h0;
      out_r <= 2'h0;
      seal_heat <= 1'b0;
      standby_heat <= 1'b0;
      alarm_relay <= 1'b0;
    end else begin
      sync1_r <= {standby_heat_input, reset_in, start_in};
      sync2_r <= sync1_r;
      start_d_r <= start_s;
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
      ctrl_r <= ctrl_nxt;
      time_r <= time_nxt;
      temp_r <= temp_nxt;
      band_r <= band_nxt;
      wr_pend_r <= wr_pend_nxt;
      wad_r <= wad_nxt;
      hrdata <= hrdata_nxt;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      reached_r <= reached_nxt;
      latch_r <= latch_nxt;
      eoc_r <= eoc_nxt;
      ecnt_r <= ecnt_nxt;
      out_r <= out_nxt;
      seal_heat <= seal_heat_nxt;
      standby_heat <= standby_nxt;
      alarm_relay <= alarm_nxt;
    end
  end
  assign process_relay = out_r[0];
  assign aux_output = out_r[1];

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_cool_end;
    st_r == ST_COOL && cool_done && !abort;
  endsequence
  a_start_launch: assert property (st_r == ST_IDLE && tc_en && start_rise && !abort |=> st_r != ST_IDLE)
    else $error("start did not launch a cycle");
  a_reset_abort: assert property (reset_s |=> st_r == ST_IDLE)
    else $error("reset did not abort the cycle");
  a_delay_to_seal: assert property (st_r == ST_DLY && cnt_r == 10'h000 && ctrl_r.seal_on_heat && !abort
    |=> st_r == ST_SEAL && cnt_r == time_r.seal_t)
    else $error("sealing did not begin at delay expiry");
  a_zero_delay: assert property (st_r == ST_IDLE && tc_en && start_rise && time_r.delay == 7'h00
    && ctrl_r.seal_on_heat && !abort |=> st_r == ST_SEAL)
    else $error("zero delay did not start sealing at once");
  a_wait_hold: assert property (st_r == ST_WAIT && !reach95 && !abort |=> st_r == ST_WAIT)
    else $error("sealing countdown began before 95 percent");
  a_relay_off: assert property (tc_en && ctrl_r.relay_mode == OM_OFF |=> !process_relay)
    else $error("relay closed in off mode");
  a_eoc_pulse: assert property (s_cool_end ##1 ctrl_r.relay_mode == OM_EOC && tc_en && !start_rise
    |=> process_relay)
    else $error("end-of-cycle pulse missing");
  a_eoc_start_open: assert property (eoc_r && start_rise && tc_en && ctrl_r.relay_mode == OM_EOC
    |=> !process_relay)
    else $error("pulse not cut by start");
  a_latch_open: assert property (st_r == ST_SEAL && !in_band ##1 !start_rise && tc_en
    && ctrl_r.relay_mode == OM_LATCH |=> !process_relay)
    else $error("latched relay not opened by excursion");
  a_standby_heat_input_seal: assert property ((st_r == ST_SEAL || st_r == ST_WAIT) && tc_en |=> !standby_heat)
    else $error("standby heat on during sealing");
  a_alarm_class: assert property (err_hard |=> alarm_relay == !$past(ctrl_r.alarm_inv))
    else $error("hard fault alarm state wrong");
  a_alarm_cal: assert property (err_cal && !err_hard && !start_s |=> alarm_relay == $past(ctrl_r.alarm_inv))
    else $error("calibration alarm state wrong");
endmodule : hsc_seq
`default_nettype wire

// ---- verilog/hsc_pkg.sv ----
// Constants, register layouts and types of the sealing-cycle sequencer.
// Assumes a 100 MHz clock; temperatures in whole degrees, times in 0.1 s ticks.
package hsc_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIME = 8'h04;
  localparam logic [7:0] OFS_TEMP = 8'h08;
  localparam logic [7:0] OFS_BAND = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam int TICK_MS = 100;
  localparam int CLK_KHZ = 100000;
  localparam int TICK_CYC = TICK_MS * CLK_KHZ;
  localparam int EOC_MS = 500;
  localparam logic [3:0] EOC_TICKS = 4'(EOC_MS / TICK_MS);
  localparam logic [19:0] PCT_FULL = 20'h64;
  localparam logic [19:0] PCT_REACH = 20'h5F;
  localparam logic [9:0] ERR_EXT_LO = 10'h065;
  localparam logic [9:0] ERR_EXT_HI = 10'h067;
  localparam logic [9:0] ERR_CAL_LO = 10'h068;
  localparam logic [9:0] ERR_CAL_HI = 10'h06A;
  localparam logic [9:0] ERR_STEP_LO = 10'h06B;
  localparam logic [9:0] ERR_STEP_HI = 10'h06C;
  localparam logic [9:0] ERR_CAL2_LO = 10'h06F;
  localparam logic [9:0] ERR_CAL2_HI = 10'h071;
  localparam logic [9:0] ERR_FRQ_LO = 10'h0C9;
  localparam logic [9:0] ERR_FRQ_HI = 10'h0CB;
  localparam logic [9:0] ERR_CFG = 10'h0D3;
  localparam logic [9:0] ERR_JMP = 10'h321;
  localparam logic [9:0] ERR_INT_LO = 10'h384;
  localparam logic [9:0] ERR_INT_HI = 10'h3E7;
  typedef enum logic [1:0] {TC_OFF = 2'h0, TC_ON = 2'h1, TC_MON = 2'h2} hsc_tc_t;
  typedef enum logic [1:0] {CM_ABS = 2'h0, CM_REL = 2'h1, CM_TIME = 2'h2} hsc_cool_t;
  typedef enum logic [2:0] {OM_OFF = 3'h0, OM_START = 3'h1, OM_REACH = 3'h2, OM_COOL = 3'h3,
                            OM_EOC = 3'h4, OM_TOL = 3'h5, OM_LATCH = 3'h6} hsc_omode_t;
  typedef enum logic [4:0] {ST_IDLE = 5'h01, ST_DLY = 5'h02, ST_WAIT = 5'h04, ST_SEAL = 5'h08,
                            ST_COOL = 5'h10} hsc_state_t;
  typedef struct packed {
    logic [18:0] rsvd;
    logic alarm_inv;
    logic [2:0] aux_mode;
    logic [2:0] relay_mode;
    logic input_length_sealing;
    logic seal_on_heat;
    logic [1:0] cool_mode;
    logic [1:0] tc_mode;
  } hsc_ctrl_t;
  typedef struct packed {
    logic [5:0] rsvd1;
    logic [9:0] seal_t;
    logic [8:0] rsvd0;
    logic [6:0] delay;
  } hsc_time_t;
  typedef struct packed {
    logic [5:0] rsvd1;
    logic [9:0] hi;
    logic [5:0] rsvd0;
    logic [9:0] lo;
  } hsc_pair_t;
  localparam hsc_ctrl_t RST_CTRL = '{rsvd: 19'h00000, alarm_inv: 1'b0, aux_mode: OM_LATCH,
    relay_mode: OM_REACH, input_length_sealing: 1'b0, seal_on_heat: 1'b0, cool_mode: CM_ABS, tc_mode: TC_OFF};
  localparam hsc_time_t RST_TIME = '{rsvd1: 6'h00, seal_t: 10'h00A, rsvd0: 9'h000, delay: 7'h00};
  localparam hsc_pair_t RST_TEMP = '{rsvd1: 6'h00, hi: 10'h032, rsvd0: 6'h00, lo: 10'h0B4};
  localparam hsc_pair_t RST_BAND = '{rsvd1: 6'h00, hi: 10'h00A, rsvd0: 6'h00, lo: 10'h00A};
endpackage : hsc_pkg

// ---- testbench/hsc_plant.sv ----
// Far-side model: heating element and band temperature seen by the sequencer.
// Assumes the heat outputs of the sequencer on the same clock; ambient is 20 degrees.
`timescale 1ns/1ns
`default_nettype none
module hsc_plant (
  input wire logic clk,           // Clock
  input wire logic sys_rst,       // Synchronous reset, active high
  input wire logic seal_heat,     // Sealing heat on
  input wire logic standby_heat,  // Standby heat on
  output logic [9:0] temp_act     // Band temperature
);
  logic [1:0] div_r;
  always_ff @(posedge clk) begin
    div_r <= div_r + 2'h1;
    if (sys_rst) begin
      temp_act <= 10'h014;
      div_r <= 2'h0;
    end else if (seal_heat && temp_act < 10'h190) begin
      temp_act <= temp_act + 10'h001;
    end else if (standby_heat && temp_act < 10'h03C) begin
      // Standby heat holds the band at 60 degrees, so cooling cannot pass below it
      temp_act <= temp_act + 10'h001;
    end else if (!(standby_heat && temp_act <= 10'h03C) && div_r == 2'h3 && temp_act > 10'h014) begin
      temp_act <= temp_act - 10'h001;
    end
  end
endmodule : hsc_plant
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the sealing-cycle sequencer: bus, cycle modes, alarm.
// Assumes hsc_seq with a 10-cycle tick and the plant model on its far side.
`timescale 1ns/1ns
`default_nettype none
module tb_top import hsc_pkg::*; ;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic start_in = 1'b0;
  logic reset_in = 1'b0;
  logic sbi = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [9:0] err_code = 10'h000;
  wire hreadyout, hresp, process_relay, aux_output, seal_heat, standby_heat, alarm_relay;
  wire [31:0] hrdata;
  wire [9:0] temp_act;
  logic [31:0] q;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  hsc_seq #(.TICK_CYCLES(10)) uut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .start_in(start_in), .reset_in(reset_in), .standby_heat_input(sbi), .temp_act(temp_act),
    .err_code(err_code), .process_relay(process_relay), .aux_output(aux_output), .seal_heat(seal_heat),
    .standby_heat(standby_heat), .alarm_relay(alarm_relay));
  hsc_plant pl (.clk(clk), .sys_rst(sys_rst), .seal_heat(seal_heat), .standby_heat(standby_heat),
    .temp_act(temp_act));
  task complete_run;
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One single transfer; entered just after a rising edge
  task ahb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : ahb
  // Waits a bounded number of cycles for relay (sel 0), sealing heat (sel 1) or aux output (sel 2)
  task wait_for(input int sel, input logic v, input int lim, input string nm);
    int i;
    logic s;
    i = 0;
    s = ~v;
    while (s !== v && i < lim) begin
      @(posedge clk);
      s = (sel == 0) ? process_relay : (sel == 1) ? seal_heat : aux_output;
      i++;
    end
    chk(nm, 32'(v), 32'(s));
  endtask : wait_for
  task t_regs;
    ahb(OFS_CTRL, 1'b0, 32'h0);
    chk("ctrl_rst", RST_CTRL, q);
    chk("aux_dflt", 32'(OM_LATCH), {29'h0, q[11:9]});
    ahb(OFS_TIME, 1'b0, 32'h0);
    chk("time_rst", RST_TIME, q);
    ahb(OFS_TEMP, 1'b0, 32'h0);
    chk("temp_rst", RST_TEMP, q);
    ahb(OFS_BAND, 1'b0, 32'h0);
    chk("band_rst", RST_BAND, q);
    ahb(8'h14, 1'b1, 32'hFFFFFFFF);
    ahb(8'h14, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("hresp_okay", 32'h0, 32'(hresp));
  endtask : t_regs
  task t_start_present;
    ahb(OFS_CTRL, 1'b1, 32'h00000C59);
    ahb(OFS_TIME, 1'b1, 32'h00030000);
    ahb(OFS_TEMP, 1'b1, 32'h00020064);
    sbi <= 1'b1;
    start_in <= 1'b1;
    wait_for(0, 1'b1, 8, "relay_on_start");
    ahb(OFS_STAT, 1'b0, 32'h0);
    chk("seal_at_start", 32'h08, {27'h0, q[4:0]});
    chk("heat_in_seal", 32'h1, 32'(seal_heat));
    chk("standby_in_seal", 32'h0, 32'(standby_heat));
    wait_for(1, 1'b0, 60, "seal_end");
    repeat (2) @(posedge clk);
    chk("standby_in_cool", 32'h1, 32'(standby_heat));
    chk("relay_in_cool", 32'h1, 32'(process_relay));
    wait_for(0, 1'b0, 60, "relay_cool_end");
    start_in <= 1'b0;
    sbi <= 1'b0;
  endtask : t_start_present
  task t_reached;
    ahb(OFS_CTRL, 1'b1, 32'h00000C81);
    ahb(OFS_TIME, 1'b1, 32'h00020002);
    ahb(OFS_TEMP, 1'b1, 32'h00320064);
    // Standby input stays low so absolute cooling can reach 50
    sbi <= 1'b0;
    start_in <= 1'b1;
    repeat (43) @(posedge clk);
    ahb(OFS_STAT, 1'b0, 32'h0);
    chk("wait_reach", 32'h04, {27'h0, q[4:0]});
    wait_for(0, 1'b1, 300, "relay_reach");
    chk("reach_temp", 32'h1, 32'(temp_act >= 10'd95 && temp_act <= 10'd100));
    ahb(OFS_STAT, 1'b0, 32'h0);
    chk("seal_after", 32'h08, {27'h0, q[4:0]});
    wait_for(0, 1'b0, 800, "relay_abs_end");
    chk("abs_cool_temp", 32'h1, 32'(temp_act < 10'd50));
    start_in <= 1'b0;
  endtask : t_reached
  task t_eoc_abort;
    ahb(OFS_CTRL, 1'b1, 32'h00000D19);
    ahb(OFS_TIME, 1'b1, 32'h00020000);
    ahb(OFS_TEMP, 1'b1, 32'h00010064);
    start_in <= 1'b1;
    repeat (5) @(posedge clk);
    start_in <= 1'b0;
    wait_for(0, 1'b1, 80, "eoc_close");
    repeat (35) @(posedge clk);
    chk("eoc_hold", 32'h1, 32'(process_relay));
    wait_for(0, 1'b0, 20, "eoc_open");
    start_in <= 1'b1;
    repeat (5) @(posedge clk);
    start_in <= 1'b0;
    wait_for(0, 1'b1, 80, "eoc_close2");
    repeat (10) @(posedge clk);
    start_in <= 1'b1;
    wait_for(0, 1'b0, 8, "eoc_cut");
    reset_in <= 1'b1;
    repeat (6) @(posedge clk);
    ahb(OFS_STAT, 1'b0, 32'h0);
    chk("reset_abort", 32'h01, {27'h0, q[4:0]});
    reset_in <= 1'b0;
    start_in <= 1'b0;
    ahb(OFS_CTRL, 1'b1, 32'h00000D1A);
    start_in <= 1'b1;
    repeat (12) @(posedge clk);
    start_in <= 1'b0;
    repeat (8) @(posedge clk);
    ahb(OFS_STAT, 1'b0, 32'h0);
    chk("release_abort", 32'h01, {27'h0, q[4:0]});
    repeat (60) @(posedge clk);
    chk("no_pulse_abort", 32'h0, 32'(process_relay));
  endtask : t_eoc_abort
  task t_alarm;
    // Each entry: error code, start level, inverted polarity, expected contact
    logic [12:0] tab [0:10];
    tab = '{13'h0340, 13'h0355, 13'h0698, 13'h0329, 13'h0361, 13'h1909, 13'h1DB1, 13'h0000,
      13'h0343, 13'h190A, 13'h069E};
    foreach (tab[i]) begin
      ahb(OFS_CTRL, 1'b1, {19'h0, tab[i][1], 12'h000});
      err_code <= tab[i][12:3];
      start_in <= tab[i][2];
      repeat (6) @(posedge clk);
      chk("alarm", 32'(tab[i][0]), 32'(alarm_relay));
      chk("relay_tc_off", 32'h0, 32'(process_relay));
    end
    start_in <= 1'b0;
    err_code <= 10'h000;
  endtask : t_alarm
  task t_tol_cool;
    // Standby heat parks the band at 60 degrees, inside 50..70 around a 60 degree target
    ahb(OFS_CTRL, 1'b1, 32'h00000159);
    ahb(OFS_TEMP, 1'b1, 32'h0001003C);
    sbi <= 1'b1;
    repeat (200) @(posedge clk);
    chk("tol_in_band", 32'h1, 32'(process_relay));
    chk("aux_off", 32'h0, 32'(aux_output));
    ahb(OFS_TEMP, 1'b1, 32'h00010064);
    repeat (4) @(posedge clk);
    chk("tol_out_band", 32'h0, 32'(process_relay));
    ahb(OFS_CTRL, 1'b1, 32'h00000619);
    ahb(OFS_TIME, 1'b1, 32'h00010001);
    ahb(OFS_TEMP, 1'b1, 32'h0002003C);
    start_in <= 1'b1;
    wait_for(2, 1'b1, 60, "aux_cool_on");
    chk("relay_off_mode", 32'h0, 32'(process_relay));
    wait_for(2, 1'b0, 30, "aux_cool_off");
    start_in <= 1'b0;
  endtask : t_tol_cool
  task t_latch_rel;
    // Seal length follows start; relative cooling ends at 100 percent of 60 degrees
    ahb(OFS_CTRL, 1'b1, 32'h00000BB5);
    ahb(OFS_TEMP, 1'b1, 32'h0064003C);
    start_in <= 1'b1;
    repeat (30) @(posedge clk);
    chk("ext_seal_held", 32'h1, 32'(seal_heat));
    start_in <= 1'b0;
    wait_for(1, 1'b0, 8, "ext_seal_end");
    ahb(OFS_STAT, 1'b0, 32'h0);
    chk("rel_cooling", 32'h10, {27'h0, q[4:0]});
    repeat (250) @(posedge clk);
    ahb(OFS_STAT, 1'b0, 32'h0);
    chk("rel_cool_end", 32'h01, {27'h0, q[4:0]});
    chk("latch_held", 32'h0, 32'(process_relay));
    chk("aux_tol", 32'h1, 32'(aux_output));
    start_in <= 1'b1;
    wait_for(0, 1'b1, 8, "latch_clear");
    start_in <= 1'b0;
    sbi <= 1'b0;
  endtask : t_latch_rel
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs();
    t_start_present();
    t_reached();
    t_eoc_abort();
    t_alarm();
    t_tol_cool();
    t_latch_rel();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
